// ---- sufc_consts.svh ----
`ifndef SUFC_CONSTS_SVH
`define SUFC_CONSTS_SVH

// ****************************************************************
// register byte addresses (printed offsets are not all multiples of
// four, so address = 4 * index)
// ****************************************************************
`define SUFC_IDX_MCAST     8'h84
`define SUFC_IDX_VLAN      8'h85
`define SUFC_IDX_SELF_IPM  8'h86
`define SUFC_IDX_RATE_PVID 8'h87
`define SUFC_ADDR_W        10

// ****************************************************************
// field positions
// ****************************************************************
`define SUFC_EN_BIT        5
`define SUFC_MAP_HI        4
`define SUFC_SELF_BIT      6
`define SUFC_RLP_HI        5
`define SUFC_RLP_LO        4
`define SUFC_QEG_BIT       3
`define SUFC_PVID_BIT      2

// ****************************************************************
// reset values (reserved bits included)
// ****************************************************************
`define SUFC_RST_MCAST     8'h40
`define SUFC_RST_VLAN      8'h00
`define SUFC_RST_SELF_IPM  8'h00
`define SUFC_RST_RATE_PVID 8'h10

// ****************************************************************
// writable bit masks; the rest is read-only
// ****************************************************************
`define SUFC_WM_MCAST      8'h3f
`define SUFC_WM_VLAN       8'h3f
`define SUFC_WM_SELF_IPM   8'h7f
`define SUFC_WM_RATE_PVID  8'h3c

// ****************************************************************
// timing
// ****************************************************************
`define SUFC_CLK_MHZ       100
`define SUFC_P16_MS        16
`define SUFC_P64_MS        64
`define SUFC_P256_MS       256
`define SUFC_CYC_PER_MS    (`SUFC_CLK_MHZ * 1000)

`endif

// ---- sufc_pkg.sv ----
package sufc_pkg;
  typedef enum logic [1:0] {
    SUFC_CLS_NONE,
    SUFC_CLS_MCAST,
    SUFC_CLS_IPMC,
    SUFC_CLS_VLAN
  } sufc_class_t;

  typedef enum logic [1:0] {
    SUFC_PER_16,
    SUFC_PER_64,
    SUFC_PER_256
  } sufc_period_t;
endpackage : sufc_pkg

// ---- sufc_period_tick.sv ----
`timescale 1ns/1ns
`include "sufc_consts.svh"

// emits a one-cycle tick at the end of each rate-limit unit period
module sufc_period_tick #(
  parameter int unsigned C16  = `SUFC_P16_MS * `SUFC_CYC_PER_MS,  // cycles of 16 ms
  parameter int unsigned C64  = `SUFC_P64_MS * `SUFC_CYC_PER_MS,  // cycles of 64 ms
  parameter int unsigned C256 = `SUFC_P256_MS * `SUFC_CYC_PER_MS  // cycles of 256 ms
) (
  input  wire logic       ref_clk,  // clock
  input  wire logic       resetn,   // async reset, low
  input  wire logic [1:0] sel,      // period code
  output logic            tick      // end of period pulse
);
  initial begin
    if (C16 < 2 || C64 < 2 || C256 < 2) begin
      $error("period counts must be at least two cycles");
    end
  end

  logic [31:0] cnt_q;
  logic [31:0] limit;

  // codes 10 and 11 both mean the long period
  assign limit = sel[1] ? C256 - 1 : (sel[0] ? C64 - 1 : C16 - 1);

  // a shortened period restarts cleanly instead of running past the limit
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule : sufc_period_tick

// ---- sufc_ctrl.sv ----
`timescale 1ns/1ns
`include "sufc_consts.svh"

// Overview of operation
// - Unknown multicast map 00000 drops the packet, 11111 floods every port.
// - Unknown multicast partial codes add ports one by one: 1-2, 1-3, 1-4.
// - Unknown VLAN policy applies only while its enable bit is set.
// - Unknown VLAN map: zero drops, all ones floods, partial codes grow.
// - Self-address filter bit set discards packets with own MAC address.
// - Self filtering is done at egress against the configured switch MAC.
// - Unknown IP multicast policy applies only while its enable is set.
// - Unknown IP multicast map: zero drops, all ones floods, partial grows.
// - Rate period code 00 16 ms, 01 64 ms, 1x 256 ms; reset 01.
// - Egress limiting is port-based when bit clear, queue-based when set.
// - PVID select set: per-source-port tag insertion from port settings.
// - PVID select clear: each ingress port's single insertion bit decides.
// - Unknown non-IP multicast policy applies only while its enable is set.
module sufc_ctrl #(
  parameter int unsigned NPORT = 5,  // switch ports
  parameter int unsigned C16   = `SUFC_P16_MS * `SUFC_CYC_PER_MS,   // 16 ms cycles
  parameter int unsigned C64   = `SUFC_P64_MS * `SUFC_CYC_PER_MS,   // 64 ms cycles
  parameter int unsigned C256  = `SUFC_P256_MS * `SUFC_CYC_PER_MS   // 256 ms cycles
) (
  input  wire logic                   ref_clk,          // 100 MHz clock
  input  wire logic                   resetn,           // async reset, low
  input  wire logic [`SUFC_ADDR_W-1:0] avs_address,     // byte address
  input  wire logic                   avs_read,         // read strobe
  input  wire logic                   avs_write,        // write strobe
  input  wire logic [31:0]            avs_writedata,    // write data
  input  wire logic [3:0]             avs_byteenable,   // byte lanes
  output logic [31:0]                 avs_readdata,     // read data
  output logic                        avs_waitrequest,  // stall
  output logic [1:0]                  avs_response,     // 00 ok, 11 decode error
  input  wire logic                   lk_valid,         // lookup result valid
  input  wire logic                   lk_miss,          // lookup found no entry
  input  wire sufc_pkg::sufc_class_t  lk_class,         // packet class
  input  wire logic [NPORT-1:0]       lk_src_port,      // source port one-hot
  input  wire logic [47:0]            pkt_da,           // destination MAC
  input  wire logic                   pkt_is_mc,        // unicast/multicast DA
  input  wire logic [47:0]            self_mac,         // switch MAC
  input  wire logic [NPORT-1:0]       pctl8_tag_map,    // per-source insert map
  input  wire logic [NPORT-1:0]       pctl0_tag_ins,    // per-port insert bit
  output logic                        fw_valid,         // decision valid
  output logic                        fw_apply,         // special policy applies
  output logic [NPORT-1:0]            fw_port_map,      // forward port set
  output logic                        fw_drop,          // drop the packet
  output logic                        fw_self_drop,     // drop as self address
  output logic                        fw_tag_insert,    // insert PVID at egress
  output logic                        eg_queue_mode,    // queue-based egress limit
  output logic [1:0]                  rl_period,        // rate period code
  output logic                        rl_tick           // period end pulse
);
  initial begin
    if (NPORT != 5) begin
      $error("port maps are five bits wide, NPORT must be 5");
    end
  end

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0] mcast_q;
  logic [7:0] vlan_q;
  logic [7:0] self_ipm_q;
  logic [7:0] rate_pvid_q;
  logic       rd_done_q;

  // ****************************************************************
  // avalon decode
  // ****************************************************************
  wire        hit_mcast = avs_address == {`SUFC_IDX_MCAST, 2'b00};
  wire        hit_vlan  = avs_address == {`SUFC_IDX_VLAN, 2'b00};
  wire        hit_self  = avs_address == {`SUFC_IDX_SELF_IPM, 2'b00};
  wire        hit_rate  = avs_address == {`SUFC_IDX_RATE_PVID, 2'b00};
  wire        hit_any   = hit_mcast | hit_vlan | hit_self | hit_rate;
  // a write lands only at the edge that accepts it, never while stalled
  wire        wr_lane0  = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire [7:0]  wdat      = avs_writedata[7:0];
  wire [7:0]  rsel      = hit_mcast ? mcast_q :
                          hit_vlan  ? vlan_q :
                          hit_self  ? self_ipm_q :
                          hit_rate  ? rate_pvid_q : 8'h00;

  // read-only bits keep their reset value regardless of what is written
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] wm);
    merge = (old & ~wm) | (nw & wm);
  endfunction : merge

  wire [7:0] mcast_d     = merge(mcast_q, wdat, `SUFC_WM_MCAST);
  wire [7:0] vlan_d      = merge(vlan_q, wdat, `SUFC_WM_VLAN);
  wire [7:0] self_ipm_d  = merge(self_ipm_q, wdat, `SUFC_WM_SELF_IPM);
  wire [7:0] rate_pvid_d = merge(rate_pvid_q, wdat, `SUFC_WM_RATE_PVID);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mcast_q     <= `SUFC_RST_MCAST;
      vlan_q      <= `SUFC_RST_VLAN;
      self_ipm_q  <= `SUFC_RST_SELF_IPM;
      rate_pvid_q <= `SUFC_RST_RATE_PVID;
    end else if (wr_lane0) begin
      if (hit_mcast) mcast_q <= mcast_d;
      if (hit_vlan) vlan_q <= vlan_d;
      if (hit_self) self_ipm_q <= self_ipm_d;
      if (hit_rate) rate_pvid_q <= rate_pvid_d;
    end
  end

  // writes and reads both take one wait cycle; read data is registered during it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_done_q       <= 1'b0;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      avs_response    <= 2'b00;
    end else begin
      rd_done_q       <= avs_read & ~rd_done_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~rd_done_q & avs_waitrequest);
      avs_readdata    <= {24'h00_0000, rsel};
      avs_response    <= hit_any ? 2'b00 : 2'b11;
    end
  end

  // ****************************************************************
  // field views
  // ****************************************************************
  wire             mc_en     = mcast_q[`SUFC_EN_BIT];
  wire [4:0]       mc_map    = mcast_q[`SUFC_MAP_HI:0];
  wire             vl_en     = vlan_q[`SUFC_EN_BIT];
  wire [4:0]       vl_map    = vlan_q[`SUFC_MAP_HI:0];
  wire             ipm_en    = self_ipm_q[`SUFC_EN_BIT];
  wire [4:0]       ipm_map   = self_ipm_q[`SUFC_MAP_HI:0];
  wire             self_en   = self_ipm_q[`SUFC_SELF_BIT];
  wire             pvid_sel  = rate_pvid_q[`SUFC_PVID_BIT];

  // ****************************************************************
  // forwarding decision
  // ****************************************************************
  wire mc_hit  = lk_miss & (lk_class == sufc_pkg::SUFC_CLS_MCAST);
  wire ipm_hit = lk_miss & (lk_class == sufc_pkg::SUFC_CLS_IPMC);
  wire vl_hit  = lk_miss & (lk_class == sufc_pkg::SUFC_CLS_VLAN);

  // each map bit is one port, so 00011/00111/01111 grow the set and 11111 floods
  wire       sel_mc  = mc_hit & mc_en;
  wire       sel_ipm = ipm_hit & ipm_en;
  wire       sel_vl  = vl_hit & vl_en;
  wire       apply_d = sel_mc | sel_ipm | sel_vl;
  wire [4:0] map_d   = sel_mc ? mc_map : sel_ipm ? ipm_map : sel_vl ? vl_map : 5'h00;

  // egress-side compare against the configured switch address
  wire self_d = self_en & (pkt_da == self_mac);

  // one-hot source port indexes the tag maps
  wire tag_d  = pvid_sel ? |(lk_src_port & pctl8_tag_map)
                         : |(lk_src_port & pctl0_tag_ins);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fw_valid      <= 1'b0;
      fw_apply      <= 1'b0;
      fw_port_map   <= '0;
      fw_drop       <= 1'b0;
      fw_self_drop  <= 1'b0;
      fw_tag_insert <= 1'b0;
    end else begin
      fw_valid      <= lk_valid;
      fw_apply      <= lk_valid & apply_d;
      fw_port_map   <= lk_valid ? map_d : 5'h00;
      fw_drop       <= lk_valid & apply_d & (map_d == 5'h00);
      fw_self_drop  <= lk_valid & self_d;
      fw_tag_insert <= lk_valid & tag_d;
    end
  end

  // ****************************************************************
  // rate-limit controls
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      eg_queue_mode <= 1'b0;
      rl_period     <= 2'b01;
    end else begin
      eg_queue_mode <= rate_pvid_q[`SUFC_QEG_BIT];
      rl_period     <= rate_pvid_q[`SUFC_RLP_HI:`SUFC_RLP_LO];
    end
  end

  logic tick_w;
  sufc_period_tick #(
    .C16  (C16),
    .C64  (C64),
    .C256 (C256)
  ) u_tick (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .sel     (rl_period),
    .tick    (tick_w)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) rl_tick <= 1'b0;
    else rl_tick <= tick_w;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_drop_zero;
    @(posedge ref_clk) disable iff (!resetn)
      (lk_valid & apply_d & (map_d == 5'h00)) |=> fw_drop & (fw_port_map == 5'h00);
  endproperty
  a_drop_zero: assert property (p_drop_zero) else $error("zero map did not drop");

  property p_map_pass;
    @(posedge ref_clk) disable iff (!resetn)
      (lk_valid & sel_mc) |=> fw_port_map == $past(mc_map);
  endproperty
  a_map_pass: assert property (p_map_pass) else $error("mcast map not applied");

  property p_vlan_en;
    @(posedge ref_clk) disable iff (!resetn)
      (lk_valid & vl_hit & ~vl_en) |=> ~fw_apply;
  endproperty
  a_vlan_en: assert property (p_vlan_en) else $error("vlan policy while disabled");

  property p_ipm_en;
    @(posedge ref_clk) disable iff (!resetn)
      (lk_valid & ipm_hit & ipm_en) |=> fw_apply & (fw_port_map == $past(ipm_map));
  endproperty
  a_ipm_en: assert property (p_ipm_en) else $error("ipm policy not applied");

  property p_self;
    @(posedge ref_clk) disable iff (!resetn)
      (lk_valid & (pkt_da == self_mac)) |=> fw_self_drop == $past(self_en);
  endproperty
  a_self: assert property (p_self) else $error("self filter wrong");

  property p_own_class;
    @(posedge ref_clk) disable iff (!resetn)
      (lk_valid & ~lk_miss) |=> ~fw_apply & ~fw_drop;
  endproperty
  a_own_class: assert property (p_own_class) else $error("policy on known packet");

  property p_qmode;
    @(posedge ref_clk) disable iff (!resetn)
      (wr_lane0 & hit_rate) |=> ##1 eg_queue_mode == $past(wdat[`SUFC_QEG_BIT], 2);
  endproperty
  a_qmode: assert property (p_qmode) else $error("egress mode stale");

  property p_ro_bits;
    @(posedge ref_clk) disable iff (!resetn)
      (mcast_q[7:6] == 2'b01) && (rate_pvid_q[1:0] == 2'b00) && (vlan_q[7:6] == 2'b00) &&
      (self_ipm_q[7] == 1'b0);
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("reserved bits changed");

  property p_tag;
    @(posedge ref_clk) disable iff (!resetn)
      (lk_valid & ~pvid_sel) |=> fw_tag_insert == $past(|(lk_src_port & pctl0_tag_ins));
  endproperty
  a_tag: assert property (p_tag) else $error("tag insert wrong");
endmodule : sufc_ctrl

// ---- test_switch_unknown_forward_ctrl.sv ----
`timescale 1ns/1ns
`include "sufc_consts.svh"

module test_switch_unknown_forward_ctrl;
  // short unit periods keep the run brief; expectations follow these values
  localparam int unsigned C16   = 16;
  localparam int unsigned C64   = 64;
  localparam int unsigned C256  = 256;
  localparam int          LIMIT = 20000;

  logic                  ref_clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [9:0]            avs_address;
  logic [31:0]           avs_writedata, avs_readdata;
  logic [3:0]            avs_byteenable;
  logic [1:0]            avs_response, rl_period;
  logic                  lk_valid, lk_miss, pkt_is_mc, fw_valid, fw_apply, fw_drop;
  logic                  fw_self_drop, fw_tag_insert, eg_queue_mode, rl_tick;
  sufc_pkg::sufc_class_t lk_class;
  logic [4:0]            lk_src_port, pctl8_tag_map, pctl0_tag_ins, fw_port_map;
  logic [47:0]           pkt_da, self_mac;
  logic [7:0]            shadow [4];
  logic [7:0]            wmask  [4];
  logic [7:0]            rstv   [4];
  logic [4:0]            codes  [6];
  int                    num_errors, num_checks, cycles;

  sufc_ctrl #(.NPORT(5), .C16(C16), .C64(C64), .C256(C256)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .lk_valid(lk_valid), .lk_miss(lk_miss),
    .lk_class(lk_class), .lk_src_port(lk_src_port), .pkt_da(pkt_da), .pkt_is_mc(pkt_is_mc),
    .self_mac(self_mac), .pctl8_tag_map(pctl8_tag_map), .pctl0_tag_ins(pctl0_tag_ins),
    .fw_valid(fw_valid), .fw_apply(fw_apply), .fw_port_map(fw_port_map), .fw_drop(fw_drop),
    .fw_self_drop(fw_self_drop), .fw_tag_insert(fw_tag_insert),
    .eg_queue_mode(eg_queue_mode), .rl_period(rl_period), .rl_tick(rl_tick));

  always #5 ref_clk = ~ref_clk;

  // ****************************************************************
  // compare and closing
  // ****************************************************************
  task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t bus %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_bus

  task automatic chk_fw(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t decision got %b exp %b", $time, got, exp);
    end
  endtask : chk_fw

  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t tick spacing got %0d exp %0d", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // bus and lookup drivers
  // ****************************************************************
  // the request stands until waitrequest is sampled low at a rising edge;
  // read data and response are taken at that same edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
    logic w;
    @(posedge ref_clk);
    avs_address    <= a;
    avs_writedata  <= {8'h00, 16'($urandom), d};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do begin
      @(posedge ref_clk);
      w  = avs_waitrequest;
      rd = avs_readdata;
      rs = avs_response;
    end while (w !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr_reg(input int i, input logic [7:0] v, input logic [3:0] be);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'b1, {8'h84 + 8'(i), 2'b00}, v, be, rd, rs);
    if (be[0]) shadow[i] = (shadow[i] & ~wmask[i]) | (v & wmask[i]);
  endtask : wr_reg

  task automatic rd_chk(input int i);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'b0, {8'h84 + 8'(i), 2'b00}, 8'h00, 4'hf, rd, rs);
    chk_bus({rs, rd}, {2'b00, 24'h0, shadow[i]}, "readback");
  endtask : rd_chk

  function automatic logic [9:0] fw_exp(input sufc_pkg::sufc_class_t c, input logic miss,
                                        input logic sm, input logic [4:0] src, t8, t0);
    logic [7:0] r;
    logic       app;
    r   = (c == sufc_pkg::SUFC_CLS_MCAST) ? shadow[0] :
          (c == sufc_pkg::SUFC_CLS_IPMC) ? shadow[2] : shadow[1];
    app = (c != sufc_pkg::SUFC_CLS_NONE) && miss && r[5];
    return {1'b1, app, app && r[4:0] == 5'h00, shadow[2][6] && sm,
            shadow[3][2] ? |(t8 & src) : |(t0 & src), app ? r[4:0] : 5'h00};
  endfunction : fw_exp

  task automatic lookup();
    sufc_pkg::sufc_class_t c;
    logic                  m, sm;
    logic [4:0]            src, t8, t0;
    logic [9:0]            gv, ev;
    c   = sufc_pkg::sufc_class_t'($urandom_range(0, 3));
    m   = $urandom_range(0, 3) != 0;
    sm  = $urandom_range(0, 1);
    src = 5'h01 << $urandom_range(0, 4);
    t8  = 5'($urandom);
    t0  = 5'($urandom);
    @(posedge ref_clk);
    lk_valid      <= 1'b1;
    lk_class      <= c;
    lk_miss       <= m;
    lk_src_port   <= src;
    pkt_is_mc     <= 1'($urandom);
    pkt_da        <= sm ? self_mac : self_mac ^ (48'h1 << $urandom_range(0, 47));
    pctl8_tag_map <= t8;
    pctl0_tag_ins <= t0;
    @(posedge ref_clk);
    lk_valid <= 1'b0;
    #1;
    gv = {fw_valid, fw_apply, fw_drop, fw_self_drop, fw_tag_insert, fw_port_map};
    ev = fw_exp(c, m, sm, src, t8, t0);
    chk_fw(gv, ev);
    @(posedge ref_clk);
    #1;
    gv = {fw_valid, fw_apply, fw_drop, fw_self_drop, fw_tag_insert, fw_port_map};
    chk_fw(gv, 10'h000);
  endtask : lookup

  task automatic wait_tick(output logic [31:0] n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (rl_tick !== 1'b1 && n < 1000);
  endtask : wait_tick

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] rd, n;
    logic [1:0]  rs;
    logic [7:0]  v;
    ref_clk = 1'b0;  resetn = 1'b0;  avs_read = 1'b0;  avs_write = 1'b0;
    avs_address = 10'h000;  avs_writedata = 32'h0;  avs_byteenable = 4'hf;
    lk_valid = 1'b0;  lk_miss = 1'b0;  lk_class = sufc_pkg::SUFC_CLS_NONE;
    lk_src_port = 5'h01;  pkt_da = 48'h0;  pkt_is_mc = 1'b0;  pctl8_tag_map = 5'h00;
    pctl0_tag_ins = 5'h00;  num_errors = 0;  num_checks = 0;  cycles = 0;
    rstv  = '{`SUFC_RST_MCAST, `SUFC_RST_VLAN, `SUFC_RST_SELF_IPM, `SUFC_RST_RATE_PVID};
    wmask = '{`SUFC_WM_MCAST, `SUFC_WM_VLAN, `SUFC_WM_SELF_IPM, `SUFC_WM_RATE_PVID};
    codes = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f};
    shadow = rstv;
    void'($urandom(32'h54525179));
    self_mac = {16'($urandom), 32'($urandom)};
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk_bus({32'h0, rl_period}, {32'h0, 2'b01}, "reset period");
    for (int i = 0; i < 4; i++) rd_chk(i);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(i, 8'hff, 4'hf);
      rd_chk(i);
      wr_reg(i, 8'h00, 4'he);
      rd_chk(i);
    end
    bus(1'b0, 10'h000, 8'h00, 4'hf, rd, rs);
    chk_bus({rs, rd}, {2'b11, 32'h0}, "unmapped read");
    bus(1'b1, 10'h3fc, 8'hff, 4'hf, rd, rs);
    chk_bus({32'h0, rs}, {32'h0, 2'b11}, "unmapped write");
    $display("test register access done");
    for (int k = 0; k < 12; k++) begin
      v = 8'($urandom);
      wr_reg(0, {v[7:6], k < 6 ? 1'b1 : v[5], codes[k % 6]}, 4'hf);
      v = 8'($urandom);
      wr_reg(1, {v[7:6], k < 6 ? 1'b1 : v[5], codes[(k + 2) % 6]}, 4'hf);
      v = 8'($urandom);
      wr_reg(2, {v[7:6], k < 6 ? 1'b1 : v[5], codes[(k + 4) % 6]}, 4'hf);
      wr_reg(3, 8'($urandom), 4'hf);
      repeat (16) lookup();
    end
    $display("test forwarding decisions done");
    for (int c = 0; c < 4; c++) begin
      v = 8'($urandom);
      wr_reg(3, {v[7:6], 2'(c), 1'(c), v[2:0]}, 4'hf);
      wait_tick(n);
      wait_tick(n);
      chk_bus({32'h0, rl_period}, {32'h0, 2'(c)}, "period code");
      chk_bus({33'h0, eg_queue_mode}, {33'h0, 1'(c)}, "egress mode");
      chk_cnt(n, c == 0 ? C16 : (c == 1 ? C64 : C256));
      rd_chk(3);
    end
    $display("test rate period done");
    tally_and_finish();
  end
endmodule : test_switch_unknown_forward_ctrl
